/* flag_pkg.sv */
package flag_pkg;
  localparam logic [3:0] RANGE_AUTO     = 4'h0_00c;
  localparam logic [3:0] RANGE_MAX      = 4'h0_00b;
  localparam logic [3:0] RANGE_MIN      = 4'h0_000;
  localparam logic [1:0] MODE_SHUTDOWN  = 2'h0_0;
  localparam logic [1:0] MODE_SINGLE    = 2'h1;
  localparam logic [3:0] ADDR_CONFIG    = 4'h1;
  localparam logic [3:0] ADDR_STATUS    = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'h4;
  localparam logic [3:0] ADDR_RANGE     = 4'h5;
  localparam logic [3:0] RANGE_RESET    = 4'h0_00c;
  localparam int         CFG_RANGE_LSB  = 12;
  localparam int         CFG_MODE_LSB   = 9;
  localparam int         CFG_OVF_BIT    = 8;
  localparam int         CFG_DONE_BIT   = 7;
  localparam int         IRQ_W          = 2;

  typedef struct packed {
    logic       done;
    logic       overload;
  } conv_event_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;
endpackage

/* flags_chk.sv */
`timescale 1ns/1ps
module flags_chk
  import flag_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        conv_end,
  input wire logic        conv_overload,
  input wire logic        abort_restart,
  input wire logic [3:0]  active_range,
  input wire logic [3:0]  range_select,
  input wire logic        overflow_flag,
  input wire logic        conversion_done_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire cfg_rd = rd && addr == ADDR_CONFIG;
  wire auto_on = range_select == RANGE_AUTO;
  sequence ovl_end; conv_end && conv_overload; endsequence
  a_abort_cause:
    assert property (abort_restart |-> conv_overload && auto_on &&
      active_range < RANGE_MAX) else $error("bad abort");
  a_range_step:
    assert property (abort_restart |=> active_range ==
      $past(active_range) + 4'h1) else $error("range not stepped");
  a_manual_ovf:
    assert property (!auto_on ##0 ovl_end |-> ##[1:2] overflow_flag)
      else $error("manual overflow lost");
  a_top_ovf:
    assert property (auto_on && active_range == RANGE_MAX ##0 ovl_end
      |-> ##[1:2] overflow_flag) else $error("top overflow lost");
  a_hold_abort:
    assert property (abort_restart |=> $stable(overflow_flag))
      else $error("overflow moved on abort");
  a_ovf_cause:
    assert property ($changed(overflow_flag) |-> $past(conv_end) ||
      $past(conv_end, 2)) else $error("overflow moved alone");
  a_done_cause:
    assert property ($rose(conversion_done_flag) |-> $past(conv_end) ||
      $past(conv_end, 2) || $past(conv_end, 3)) else $error("done alone");
  a_read_clear:
    assert property (cfg_rd && !conv_end && !$past(conv_end) |=>
      !conversion_done_flag) else $error("read kept done");
  a_shut_keep:
    assert property (wr && addr == ADDR_CONFIG && wdata[10:9] ==
      MODE_SHUTDOWN |=> !$fell(conversion_done_flag)) else $error("shut");
  a_read_idle:
    assert property (!rd |=> rdata == 16'h0000) else $error("rdata idle");
endmodule
bind overflow_ready_flags flags_chk flags_chk_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .conv_end(conv_end), .conv_overload(conv_overload),
  .abort_restart(abort_restart), .active_range(active_range),
  .range_select(range_select), .overflow_flag(overflow_flag),
  .conversion_done_flag(conversion_done_flag));

/* front_end_model.sv */
`timescale 1ns/1ps
module front_end_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] n_ovl,
  input  wire logic       abort_restart,
  output logic            conv_start = 0,
  output logic            conv_end = 0,
  output logic            conv_overload = 0,
  output logic            busy = 0
);
  int n;
  logic ab;
  initial begin
    forever begin
      @(posedge clk iff go);
      n = n_ovl;
      busy <= 1;
      conv_start <= 1;
      @(posedge clk) conv_start <= 0;
      // restart after every abort the block signals
      do begin
        repeat (3) @(posedge clk);
        conv_end <= 1;
        conv_overload <= (n > 0);
        n--;
        #1 ab = abort_restart;
        @(posedge clk);
        conv_end <= 0;
        conv_overload <= 0;
      end while (ab);
      busy <= 0;
    end
  end
endmodule

/* overflow_ready_flags.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - range code 1100b selects automatic ranging
// - overflow flag high only on overflow
// - overflow flag recomputed on each measurement
// - manual range flags transient overloads too
// - auto mode flags only beyond top range
// - auto overflow aborts, raises range, restarts
// - stepping repeats until clean or maximum
// - auto overflow flag updated after stepping ends
// - conversion done flag set on completion
// - config read or non-shutdown write clears done
// - shutdown write leaves done flag alone
module overflow_ready_flags
  import flag_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        conv_start,
  input  wire logic        conv_end,
  input  wire logic        conv_overload,
  output logic             abort_restart,
  output logic      [3:0]  active_range,
  output logic      [3:0]  range_select,
  output logic      [1:0]  mode,
  output logic             overflow_flag,
  output logic             conversion_done_flag,
  output logic             irq
);
  logic        rst_meta_reg;
  logic        rst_sync_reg;
  logic [3:0]  range_reg;
  logic [1:0]  mode_reg;
  logic        ovf_reg;
  logic [15:0] rdata_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [15:0] rdata_next;
  logic [15:0] cfg_word;
  logic        cfg_rd;
  logic        cfg_wr;
  logic        done_clr;
  logic        seq_done;
  logic        seq_overflow;
  logic        done_q;
  conv_event_t ev;
  bus_req_t    req;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign ev  = '{done: conv_end, overload: conv_overload};

  range_stepper u_step (
    .clk           (ref_clk),
    .rst_n         (rst_sync_reg),
    .start         (conv_start),
    .range_select  (range_reg),
    .ev            (ev),
    .abort_restart (abort_restart),
    .active_range  (active_range),
    .seq_done      (seq_done),
    .seq_overflow  (seq_overflow)
  );

  assign cfg_rd   = req.rd && (req.addr == ADDR_CONFIG);
  assign cfg_wr   = req.wr && (req.addr == ADDR_CONFIG);
  assign done_clr = cfg_rd ||
    (cfg_wr && (req.wdata[CFG_MODE_LSB +: 2] != MODE_SHUTDOWN));

  sticky_bit u_done (
    .clk   (ref_clk),
    .rst_n (rst_sync_reg),
    .set   (seq_done),
    .clr   (done_clr),
    .q     (done_q)
  );

  assign irq_set = {seq_done && seq_overflow, seq_done};
  assign irq_clr = (req.wr && (req.addr == ADDR_IRQ_CLR))
                 ? req.wdata[IRQ_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
      sticky_bit u_irq (
        .clk   (ref_clk),
        .rst_n (rst_sync_reg),
        .set   (irq_set[gi]),
        .clr   (irq_clr[gi]),
        .q     (irq_stat[gi])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      range_reg  <= RANGE_RESET;
      mode_reg   <= MODE_SHUTDOWN;
      irq_en_reg <= '0;
    end else begin
      if (cfg_wr) begin
        range_reg <= req.wdata[CFG_RANGE_LSB +: 4];
        mode_reg  <= req.wdata[CFG_MODE_LSB +: 2];
      end else if (seq_done && mode_reg == MODE_SINGLE) begin
        mode_reg  <= MODE_SHUTDOWN;
      end
      if (req.wr && (req.addr == ADDR_IRQ_EN)) begin
        irq_en_reg <= req.wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ovf_reg <= 1'b0;
    end else if (seq_done) begin
      ovf_reg <= seq_overflow;
    end
  end

  assign cfg_word = {range_reg, 1'b0, mode_reg, ovf_reg, done_q, 7'h0_0};

  assign rdata_next =
      !req.rd                      ? 16'h0_000
    : (req.addr == ADDR_CONFIG)    ? cfg_word
    : (req.addr == ADDR_STATUS)    ? {14'h0_000, irq_stat}
    : (req.addr == ADDR_IRQ_EN)    ? {14'h0_000, irq_en_reg}
    : (req.addr == ADDR_RANGE)     ? {12'h0_000, active_range}
    : 16'h0_000;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_reg <= 16'h0_000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata                = rdata_reg;
  assign range_select         = range_reg;
  assign mode                 = mode_reg;
  assign overflow_flag        = ovf_reg;
  assign conversion_done_flag = done_q;
  assign irq                  = |(irq_stat & irq_en_reg);
endmodule

/* range_stepper.sv */
`timescale 1ns/1ps
module range_stepper
  import flag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [3:0] range_select,
  input  wire conv_event_t ev,
  output logic            abort_restart,
  output logic [3:0]      active_range,
  output logic            seq_done,
  output logic            seq_overflow
);
  logic [3:0] range_reg;
  logic [3:0] range_next;
  logic       auto_mode;
  logic       at_max;
  logic       step_up;
  logic       done_reg;
  logic       ovf_reg;

  assign auto_mode     = (range_select == RANGE_AUTO);
  assign at_max        = (range_reg == RANGE_MAX);
  assign step_up       = auto_mode && ev.overload && !at_max;
  assign abort_restart = step_up;
  assign range_next    = start ? (auto_mode ? RANGE_MIN : range_select)
                       : step_up ? range_reg + 4'h1 : range_reg;
  assign active_range  = range_reg;
  assign seq_done      = done_reg;
  assign seq_overflow  = ovf_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      range_reg <= RANGE_MIN;
      done_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
    end else begin
      range_reg <= range_next;
      // completion only when no further step is pending
      done_reg  <= ev.done && !step_up;
      // manual: any transient overload counts; auto: only at top range
      ovf_reg   <= ev.overload && (!auto_mode || at_max);
    end
  end
endmodule

/* sticky_bit.sv */
`timescale 1ns/1ps
module sticky_bit (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench
  import flag_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0;
  logic [4:0] n_ovl = 0;
  logic [15:0] rdata;
  logic [3:0] active_range, range_select;
  logic [1:0] mode;
  logic conv_start, conv_end, conv_overload, abort_restart, busy;
  logic overflow_flag, conversion_done_flag, irq;
  int err_total = 0;
  int checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  overflow_ready_flags overflow_ready_flags_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .conv_start(conv_start), .conv_end(conv_end),
    .conv_overload(conv_overload), .abort_restart(abort_restart),
    .active_range(active_range), .range_select(range_select),
    .mode(mode), .overflow_flag(overflow_flag),
    .conversion_done_flag(conversion_done_flag), .irq(irq));
  front_end_model front_end_model_i (.clk(ref_clk), .go(go),
    .n_ovl(n_ovl), .abort_restart(abort_restart),
    .conv_start(conv_start), .conv_end(conv_end),
    .conv_overload(conv_overload), .busy(busy));
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge ref_clk) wr <= 0;
    repeat (2) @(negedge ref_clk);
  endtask
  task rd_reg(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge ref_clk) {addr, rd} <= {a, 1'b1};
    @(posedge ref_clk) rd <= 0;
    @(negedge ref_clk) chk(nm, rdata, e);
  endtask
  task conv(input logic [4:0] n);
    @(posedge ref_clk) {go, n_ovl} <= {1'b1, n};
    @(posedge ref_clk) go <= 0;
    // busy rises by non-blocking assignment at this edge, so let it settle
    @(posedge ref_clk);
    for (int i = 0; i < 300 && busy; i++) @(posedge ref_clk);
    repeat (4) @(negedge ref_clk);
  endtask
  task end_sim;
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    repeat (3) @(posedge ref_clk);
    chk("range", range_select, RANGE_RESET);
    rd_reg(ADDR_CONFIG, 16'hc000, "cfg");
    rd_reg(4'hf, 16'h0000, "unmapped");
    wr_reg(ADDR_IRQ_EN, 16'h0003);
    wr_reg(ADDR_CONFIG, 16'h5200);
    conv(1);
    chk("ovf", overflow_flag, 1);
    chk("done", conversion_done_flag, 1);
    chk("irq", irq, 1);
    rd_reg(ADDR_STATUS, 16'h0003, "status");
    rd_reg(ADDR_CONFIG, 16'h5180, "cfg");
    repeat (2) @(negedge ref_clk);
    chk("done", conversion_done_flag, 0);
    wr_reg(ADDR_IRQ_CLR, 16'h0003);
    chk("irq", irq, 0);
    wr_reg(ADDR_CONFIG, 16'h5200);
    conv(0);
    chk("ovf", overflow_flag, 0);
    chk("mode", mode, MODE_SHUTDOWN);
    wr_reg(ADDR_CONFIG, 16'h5000);
    chk("done", conversion_done_flag, 1);
    wr_reg(ADDR_CONFIG, 16'hc200);
    chk("done", conversion_done_flag, 0);
    conv(3);
    chk("range", active_range, 4'h3);
    chk("ovf", overflow_flag, 0);
    chk("done", conversion_done_flag, 1);
    wr_reg(ADDR_CONFIG, 16'hc200);
    conv(20);
    chk("range", active_range, RANGE_MAX);
    chk("ovf", overflow_flag, 1);
    end_sim;
  end
endmodule
